// ==== cmb_consts.vh ====
`ifndef CMB_CONSTS_VH
`define CMB_CONSTS_VH
// mailbox object types
`define CMB_MOT_DIS 3'h0
`define CMB_MOT_RX 3'h1
`define CMB_MOT_RXOVR 3'h2
`define CMB_MOT_TX 3'h3
`define CMB_MOT_CONS 3'h4
`define CMB_MOT_PROD 3'h5
// mode register field positions
`define CMB_MODE_MOT_LO 16
`define CMB_MODE_MOT_HI 18
`define CMB_MODE_PRI_LO 8
`define CMB_MODE_PRI_HI 11
`define CMB_MODE_TRIG_LO 0
`define CMB_MODE_TRIG_HI 7
// id register: bit 29 selects extended format
`define CMB_ID_EXT_BIT 29
`define CMB_STD_LO 18
`define CMB_ID_RST 32'h0000_0000
`define CMB_MASK_RST 32'h0000_0000
`define CMB_MODE_RST 32'h0000_0000
`define CMB_DATA_RST 64'h0000_0000_0000_0000
`endif

// ==== cmb_fifo.v ====
`timescale 1ns/1ps
module cmb_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire mclk,
  input wire srst,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem_q[rp_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always @(posedge mclk)
  begin
    if (srst)
    begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        mem_q[wp_q] <= in_data;
        wp_q <= (wp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
      end
      if (pop)
        rp_q <= (rp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_q + 1'b1;
      if (push && !pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop && !push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule

// ==== cmb_mailbox.v ====
`timescale 1ns/1ps
`include "cmb_consts.vh"
module cmb_mailbox #(
  parameter NMB = 8,
  parameter MBW = 3,
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  input wire mclk,
  input wire srst,
  // software side: one mailbox written per cycle
  input wire cfg_we,
  input wire [MBW-1:0] cfg_idx,
  input wire [31:0] cfg_mode,
  input wire [31:0] cfg_id,
  input wire [31:0] cfg_mask,
  input wire [63:0] cfg_data,
  input wire [3:0] cfg_len,
  input wire [NMB-1:0] xfer_req,
  input wire time_trig_mode,
  input wire [15:0] timer_val,
  // received frames from the protocol engine
  input wire rx_valid,
  output reg rx_ready,
  input wire [28:0] rx_id,
  input wire rx_ext,
  input wire rx_rtr,
  input wire [3:0] rx_len,
  input wire [63:0] rx_data,
  // transmit requests to the protocol engine
  output reg tx_valid,
  input wire tx_ready,
  output reg [28:0] tx_id,
  output reg tx_ext,
  output reg tx_rtr,
  output reg [3:0] tx_len,
  output reg [63:0] tx_data,
  output reg [MBW-1:0] tx_mb,
  input wire tx_done,
  input wire tx_abort,
  // status readback
  input wire [MBW-1:0] rd_idx,
  output reg [31:0] rd_id,
  output reg [31:0] rd_family,
  output reg [63:0] rd_data,
  output reg [3:0] rd_len,
  output reg [NMB-1:0] mb_ready,
  output reg [NMB-1:0] tx_ok,
  output reg [NMB-1:0] tx_aborted
);
  localparam FW = 29 + 1 + 1 + 4 + 64;
  // ****************************************
  // receive frame buffer
  // ****************************************
  wire [FW-1:0] fq_data;
  wire fq_valid;
  wire fq_in_ready;
  reg fq_pop;
  // the buffer absorbs bursts while the match stage is busy storing
  cmb_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .mclk(mclk),
    .srst(srst),
    .in_data({rx_id, rx_ext, rx_rtr, rx_len, rx_data}),
    // only a frame offered while ready is high enters
    .in_valid(rx_valid && rx_ready),
    .in_ready(fq_in_ready),
    .out_data(fq_data),
    .out_valid(fq_valid),
    .out_ready(fq_pop)
  );
  wire [28:0] f_id = fq_data[FW-1:FW-29];
  wire f_ext = fq_data[69];
  wire f_rtr = fq_data[68];
  wire [3:0] f_len = fq_data[67:64];
  wire [63:0] f_dat = fq_data[63:0];
  // standard ids move up to the mailbox layout before any compare or store
  wire [28:0] f_aid = f_ext ? f_id : {f_id[10:0], 18'h0};
  // ****************************************
  // mailbox storage
  // ****************************************
  reg [31:0] mode_q [0:NMB-1];
  reg [31:0] id_q [0:NMB-1];
  reg [31:0] mask_q [0:NMB-1];
  reg [31:0] fam_q [0:NMB-1];
  reg [63:0] data_q [0:NMB-1];
  reg [3:0] len_q [0:NMB-1];
  reg [NMB-1:0] locked_q;
  reg [NMB-1:0] pend_q;
  reg [NMB-1:0] rtrpend_q;
  reg busy_q;
  reg [MBW-1:0] cur_q;
  // ****************************************
  // acceptance
  // ****************************************
  reg [NMB-1:0] hit;
  reg [NMB-1:0] prod_hit;
  reg [2:0] mailbox_object_type;
  reg [28:0] fid;
  reg [28:0] mid;
  reg [28:0] mmask;
  integer i;
  always @*
  begin
    hit = {NMB{1'b0}};
    prod_hit = {NMB{1'b0}};
    mailbox_object_type = 3'h0;
    fid = 29'h0;
    mid = 29'h0;
    mmask = 29'h0;
    for (i = 0; i < NMB; i = i + 1)
    begin
      mailbox_object_type = mode_q[i][`CMB_MODE_MOT_HI:`CMB_MODE_MOT_LO];
      // standard ids sit in the upper eleven bits of the field
      fid = f_aid;
      mid = id_q[i][28:0];
      mmask = mask_q[i][28:0];
      if ((id_q[i][`CMB_ID_EXT_BIT] == f_ext) &&
          ((fid & mmask) == (mid & mmask)))
      begin
        // duplicates just all match; priority encoder resolves them
        if (!f_rtr && !locked_q[i] &&
            ((mailbox_object_type == `CMB_MOT_RX) || (mailbox_object_type == `CMB_MOT_RXOVR) ||
             ((mailbox_object_type == `CMB_MOT_CONS) && rtrpend_q[i])))
          hit[i] = 1'b1;
        // remote frames never store; they only arm producers
        if (f_rtr && (mailbox_object_type == `CMB_MOT_PROD))
          prod_hit[i] = 1'b1;
      end
    end
  end
  reg hit_any;
  reg [MBW-1:0] hit_idx;
  integer k;
  always @*
  begin
    hit_any = 1'b0;
    hit_idx = {MBW{1'b0}};
    for (k = NMB - 1; k >= 0; k = k - 1)
      if (hit[k])
      begin
        hit_any = 1'b1;
        hit_idx = k[MBW-1:0];
      end
  end
  // pack bits the mask leaves out, right justified
  function [31:0] pack_family;
    input [28:0] idv;
    input [28:0] mk;
    integer j;
    reg [31:0] acc;
    begin
      acc = 32'h0000_0000;
      for (j = 28; j >= 0; j = j - 1)
        if (!mk[j])
          acc = {acc[30:0], idv[j]};
      pack_family = acc;
    end
  endfunction
  // ****************************************
  // transmit arbitration
  // ****************************************
  reg [NMB-1:0] eligible;
  reg tx_any;
  reg [MBW-1:0] tx_sel;
  reg [3:0] best_pri;
  integer t;
  always @*
  begin
    eligible = pend_q;
    tx_any = 1'b0;
    tx_sel = {MBW{1'b0}};
    best_pri = 4'hf;
    for (t = 0; t < NMB; t = t + 1)
    begin
      // time triggered: wait for the low timer byte to equal the trigger
      if (time_trig_mode && !rtrpend_q[t] &&
          (timer_val[7:0] != mode_q[t][`CMB_MODE_TRIG_HI:`CMB_MODE_TRIG_LO]))
        eligible[t] = 1'b0;
      // lower value is higher priority; strict compare keeps lowest index
      if (eligible[t] && (!tx_any ||
          mode_q[t][`CMB_MODE_PRI_HI:`CMB_MODE_PRI_LO] < best_pri))
      begin
        tx_any = 1'b1;
        tx_sel = t[MBW-1:0];
        best_pri = mode_q[t][`CMB_MODE_PRI_HI:`CMB_MODE_PRI_LO];
      end
    end
  end
  // ****************************************
  // sequential update
  // ****************************************
  integer m;
  always @(posedge mclk)
  begin
    if (srst)
    begin
      for (m = 0; m < NMB; m = m + 1)
      begin
        mode_q[m] <= `CMB_MODE_RST;
        id_q[m] <= `CMB_ID_RST;
        mask_q[m] <= `CMB_MASK_RST;
        fam_q[m] <= 32'h0000_0000;
        data_q[m] <= `CMB_DATA_RST;
        len_q[m] <= 4'h0;
      end
      locked_q <= {NMB{1'b0}};
      pend_q <= {NMB{1'b0}};
      rtrpend_q <= {NMB{1'b0}};
      busy_q <= 1'b0;
      cur_q <= {MBW{1'b0}};
      tx_valid <= 1'b0;
      tx_id <= 29'h0;
      tx_ext <= 1'b0;
      tx_rtr <= 1'b0;
      tx_len <= 4'h0;
      tx_data <= 64'h0000_0000_0000_0000;
      tx_mb <= {MBW{1'b0}};
      tx_ok <= {NMB{1'b0}};
      tx_aborted <= {NMB{1'b0}};
      rx_ready <= 1'b0;
      fq_pop <= 1'b0;
    end
    else
    begin
      // ready drops for a cycle after each take,
      // so a high ready always has room behind it
      rx_ready <= fq_in_ready && !(rx_valid && rx_ready);
      fq_pop <= 1'b0;
      // transfer requests: unlock and arm; a same-cycle clear by cfg_we or by completion wins over the set
      for (m = 0; m < NMB; m = m + 1)
        if (xfer_req[m])
        begin
          locked_q[m] <= 1'b0;
          if ((mode_q[m][`CMB_MODE_MOT_HI:`CMB_MODE_MOT_LO] == `CMB_MOT_TX) ||
              (mode_q[m][`CMB_MODE_MOT_HI:`CMB_MODE_MOT_LO] == `CMB_MOT_CONS))
            pend_q[m] <= 1'b1;
          tx_ok[m] <= 1'b0;
          tx_aborted[m] <= 1'b0;
        end
      if (cfg_we)
      begin
        mode_q[cfg_idx] <= cfg_mode;
        id_q[cfg_idx] <= cfg_id;
        mask_q[cfg_idx] <= cfg_mask;
        data_q[cfg_idx] <= cfg_data;
        len_q[cfg_idx] <= cfg_len;
        locked_q[cfg_idx] <= 1'b0;
        pend_q[cfg_idx] <= 1'b0;
        rtrpend_q[cfg_idx] <= 1'b0;
      end
      // one frame per two cycles: pop pulse lands before next look
      if (fq_valid && !fq_pop && !cfg_we)
      begin
        fq_pop <= 1'b1;
        if (hit_any)
        begin
          // stored id keeps the mailbox layout so the next compare still lines up
          id_q[hit_idx] <= {2'b00, f_ext, f_aid};
          fam_q[hit_idx] <= pack_family(f_aid, mask_q[hit_idx][28:0]);
          data_q[hit_idx] <= f_dat;
          len_q[hit_idx] <= f_len;
          rtrpend_q[hit_idx] <= 1'b0;
          if (mode_q[hit_idx][`CMB_MODE_MOT_HI:`CMB_MODE_MOT_LO] != `CMB_MOT_RXOVR)
            locked_q[hit_idx] <= 1'b1;
        end
        for (m = 0; m < NMB; m = m + 1)
          if (prod_hit[m])
            pend_q[m] <= 1'b1;
      end
      // transmit launch and completion
      if (!busy_q && !tx_valid && tx_any && !cfg_we)
      begin
        tx_valid <= 1'b1;
        tx_mb <= tx_sel;
        tx_id <= id_q[tx_sel][28:0];
        tx_ext <= id_q[tx_sel][`CMB_ID_EXT_BIT];
        tx_rtr <= (mode_q[tx_sel][`CMB_MODE_MOT_HI:`CMB_MODE_MOT_LO] == `CMB_MOT_CONS);
        tx_len <= len_q[tx_sel];
        tx_data <= data_q[tx_sel];
        busy_q <= 1'b1;
        cur_q <= tx_sel;
      end
      else if (tx_valid && tx_ready)
        tx_valid <= 1'b0;
      if (busy_q && !tx_valid && (tx_done || tx_abort))
      begin
        busy_q <= 1'b0;
        pend_q[cur_q] <= 1'b0;
        tx_ok[cur_q] <= tx_done;
        tx_aborted[cur_q] <= tx_abort && !tx_done;
        if (tx_done && tx_rtr)
          rtrpend_q[cur_q] <= 1'b1;
      end
    end
  end
  // ****************************************
  // readback
  // ****************************************
  always @(posedge mclk)
  begin
    if (srst)
    begin
      rd_id <= 32'h0000_0000;
      rd_family <= 32'h0000_0000;
      rd_data <= 64'h0000_0000_0000_0000;
      rd_len <= 4'h0;
      mb_ready <= {NMB{1'b0}};
    end
    else
    begin
      // readback trails rd_idx by one cycle
      rd_id <= id_q[rd_idx];
      rd_family <= fam_q[rd_idx];
      rd_data <= data_q[rd_idx];
      rd_len <= len_q[rd_idx];
      mb_ready <= locked_q;
    end
  end
endmodule

// ==== cmb_mailbox_chk.sv ====
`timescale 1ns/1ps
module cmb_mailbox_chk #(
  parameter NMB = 8,
  parameter MBW = 3
) (
  input wire mclk,
  input wire srst,
  input wire cfg_we,
  input wire [NMB-1:0] xfer_req,
  input wire tx_valid,
  input wire tx_ready,
  input wire [28:0] tx_id,
  input wire [MBW-1:0] tx_mb,
  input wire tx_done,
  input wire tx_abort,
  input wire [NMB-1:0] mb_ready,
  input wire [NMB-1:0] tx_ok,
  input wire [NMB-1:0] tx_aborted
);
  // ********
  // checks
  // ********
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  a_reset_clear: assert property (
    disable iff (1'h0) srst |=> !tx_valid && tx_ok == 0)
    else $error("reset left outputs set");
  a_wait_hold: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_mb))
    else $error("request changed before ready");
  a_idle_stable: assert property (
    !tx_valid |-> $stable(tx_mb) && $stable(tx_id))
    else $error("transmit fields moved while idle");
  a_done_ok: assert property (
    tx_done && !tx_abort |=> tx_ok[$past(tx_mb)])
    else $error("done not reported");
  a_abort_flag: assert property (
    tx_abort && !tx_done |=> tx_aborted[$past(tx_mb)])
    else $error("abort not reported");
  a_ok_sticky: assert property (
    !cfg_we && xfer_req == 0 |=> (tx_ok & $past(tx_ok)) == $past(tx_ok))
    else $error("sent flag lost");
  a_xfer_clear: assert property (
    xfer_req[5] && !tx_done && !tx_abort |=> !tx_ok[5])
    else $error("request did not clear flag");
  // mb_ready trails the lock state by one register stage
  a_lock_hold: assert property (
    !cfg_we && xfer_req == 0 |-> ##2 (mb_ready & $past(mb_ready)) == $past(mb_ready))
    else $error("locked mailbox released");
  a_one_flight: assert property (
    tx_done || tx_abort |-> !tx_valid)
    else $error("launch during completion");
endmodule
bind cmb_mailbox cmb_mailbox_chk #(.NMB(NMB), .MBW(MBW)) cmb_mailbox_chk_i (.mclk, .srst,
  .cfg_we, .xfer_req, .tx_valid, .tx_ready, .tx_id, .tx_mb, .tx_done, .tx_abort, .mb_ready,
  .tx_ok, .tx_aborted);

// ==== cmb_bus_model.sv ====
`timescale 1ns/1ps
module cmb_bus_model (
  input logic mclk,
  input logic tx_valid,
  input int lat,
  input logic fail,
  output logic tx_ready,
  output logic tx_done,
  output logic tx_abort
);
  // *********************
  // slow engine, one frame
  // *********************
  initial
  begin
    tx_ready = 1'h0;
    tx_done = 1'h0;
    tx_abort = 1'h0;
    forever
    begin
      @(negedge mclk);
      if (tx_valid === 1'h1)
      begin
        repeat (lat) @(negedge mclk);
        tx_ready = 1'h1;
        @(negedge mclk);
        tx_ready = 1'h0;
        // completion only after the request has dropped
        repeat (lat + 1) @(negedge mclk);
        tx_done = !fail;
        tx_abort = fail;
        @(negedge mclk);
        tx_done = 1'h0;
        tx_abort = 1'h0;
      end
    end
  end
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
  logic mclk = 1'h0;
  logic srst = 1'h1;
  logic cfg_we = 1'h0, time_trig_mode = 1'h0, rx_valid = 1'h0, rx_ext, rx_rtr, fail = 1'h0;
  logic [2:0] cfg_idx = '0, rd_idx = '0, tx_mb;
  logic [31:0] cfg_mode = '0, cfg_id = '0, cfg_mask = '0, rd_id, rd_family;
  logic [63:0] cfg_data = '0, rx_data = '0, tx_data, rd_data;
  logic [7:0] xfer_req = '0, mb_ready, tx_ok, tx_aborted;
  logic [28:0] rx_id = '0, tx_id;
  logic [15:0] timer_val = '0;
  logic [3:0] tx_len, rd_len, cfg_len = 4'h8, rx_len = 4'h8;
  logic rx_ready, tx_valid, tx_ready, tx_ext, tx_rtr, tx_done, tx_abort;
  int mismatches = 0, num_checks = 0, lat = 6, n;
  always #2 mclk = ~mclk;
  initial {rx_ext, rx_rtr} = 2'h0;
  cmb_mailbox cmb_mailbox_i (.mclk, .srst, .cfg_we, .cfg_idx, .cfg_mode, .cfg_id, .cfg_mask,
    .cfg_data, .cfg_len, .xfer_req, .time_trig_mode, .timer_val, .rx_valid, .rx_ready,
    .rx_id, .rx_ext, .rx_rtr, .rx_len, .rx_data, .tx_valid, .tx_ready, .tx_id, .tx_ext,
    .tx_rtr, .tx_len, .tx_data, .tx_mb, .tx_done, .tx_abort, .rd_idx, .rd_id, .rd_family,
    .rd_data, .rd_len, .mb_ready, .tx_ok, .tx_aborted);
  cmb_bus_model cmb_bus_model_i (.mclk, .tx_valid, .lat, .fail, .tx_ready, .tx_done, .tx_abort);
  // ***************
  // access tasks
  // ***************
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [63:0] g, input logic [63:0] e);
    num_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task tick(input int k);
    repeat (k) @(negedge mclk);
  endtask
  task cfg(input logic [2:0] i, input logic [31:0] m, d, k, input logic [63:0] v);
    {cfg_idx, cfg_mode, cfg_id, cfg_mask, cfg_data} = {i, m, d, k, v};
    cfg_we = 1'h1;
    tick(1);
    cfg_we = 1'h0;
    tick(1);
  endtask
  task xfer(input logic [7:0] v);
    xfer_req = v;
    tick(1);
    xfer_req = '0;
    tick(1);
  endtask
  // ready seen high at a falling edge means the next rising edge takes the frame
  task rx(input logic [28:0] id, input logic e, r, input logic [63:0] v);
    {rx_id, rx_ext, rx_rtr, rx_data} = {id, e, r, v};
    rx_valid = 1'h1;
    for (n = 0; rx_ready !== 1'h1; n++)
    begin
      if (n > 50)
      begin
        mismatches++;
        end_sim;
      end
      tick(1);
    end
    tick(1);
    rx_valid = 1'h0;
    tick(4);
  endtask
  // fields are read while the request stands, then the drop is awaited
  task wait_tx(input logic [2:0] mb, input logic r);
    for (n = 0; tx_valid !== 1'h1; n++)
    begin
      if (n > 200)
      begin
        mismatches++;
        end_sim;
      end
      tick(1);
    end
    chk({tx_mb, tx_rtr}, {mb, r});
    for (n = 0; tx_valid !== 1'h0; n++)
    begin
      if (n > 50)
      begin
        mismatches++;
        end_sim;
      end
      tick(1);
    end
  endtask
  task rd(input logic [2:0] i);
    rd_idx = i;
    tick(2);
  endtask
  initial
  begin
    tick(8);
    srst = 1'h0;
    tick(1);
    chk({mb_ready, tx_ok, tx_aborted, tx_valid}, 0);
    // chained pair with one id; the mask frees id bits 4, 1 and 0 for the family
    cfg(1, 32'h0001_0000, 32'h2000_0100, 32'h1FFF_FFEC, 0);
    cfg(2, 32'h0001_0000, 32'h2000_0100, 32'h1FFF_FFEC, 0);
    rx(29'h0000_0111, 1, 0, 64'h0000_0000_0000_00A1);
    chk(mb_ready, 8'h02);
    rd(1);
    chk({rd_id, rd_family}, 64'h2000_0111_0000_0005);
    rx(29'h0000_0102, 1, 0, 64'h0000_0000_0000_00B2);
    chk(mb_ready, 8'h06);
    chk(rd_data, 64'h0000_0000_0000_00A1);
    rd(2);
    chk({rd_family, rd_data[31:0]}, 64'h0000_0002_0000_00B2);
    xfer(8'h02);
    chk(mb_ready, 8'h04);
    cfg(3, 32'h0002_0000, 32'h1234_0000, 32'h1FFF_FFFF, 0);
    rx(29'h1234_0000, 1, 0, 64'h0000_0000_0000_00C3);
    rd(3);
    chk(rd_data, 0);
    // standard frames carry their eleven id bits at the bottom
    rx(29'h0000_048D, 0, 0, 64'h0000_0000_0000_00D4);
    rx_len = 4'h2;
    rx(29'h0000_048D, 0, 0, 64'h0000_0000_0000_00E5);
    rd(3);
    chk(rd_data, 64'h0000_0000_0000_00E5);
    chk(rd_len, 4'h2);
    chk(rd_id, 32'h1234_0000);
    rd(3);
    chk(rd_data, 64'h0000_0000_0000_00E5);
    cfg_len = 4'h3;
    cfg(0, 32'h0005_0000, 32'h0A00_0000, 32'h1FFF_FFFF, 64'h1111_2222_3333_4444);
    rx(29'h0000_0280, 0, 1, 0);
    wait_tx(0, 0);
    chk(tx_data, 64'h1111_2222_3333_4444);
    chk({tx_len, tx_ext, tx_id}, {4'h3, 1'h0, 29'h0A00_0000});
    cfg(5, 32'h0003_0200, 32'h0100_0000, 0, 5);
    cfg(6, 32'h0003_0100, 32'h0100_0000, 0, 6);
    cfg(7, 32'h0003_0100, 32'h0100_0000, 0, 7);
    xfer(8'hE0);
    wait_tx(6, 0);
    wait_tx(7, 0);
    wait_tx(5, 0);
    tick(20);
    chk(tx_ok, 8'hE1);
    fail = 1'h1;
    xfer(8'h20);
    wait_tx(5, 0);
    tick(20);
    chk({tx_aborted, tx_ok}, 16'h20C1);
    fail = 1'h0;
    cfg(4, 32'h0004_0000, 32'h0600_0000, 32'h1FFF_FFFF, 0);
    xfer(8'h10);
    wait_tx(4, 1);
    tick(20);
    rx(29'h0000_0180, 0, 0, 64'h0000_0000_0000_0077);
    rx(29'h0000_0180, 0, 0, 64'h0000_0000_0000_0088);
    rd(4);
    chk({mb_ready, rd_data[7:0]}, 16'h1477);
    time_trig_mode = 1'h1;
    timer_val = 16'h0010;
    cfg(5, 32'h0003_0240, 32'h0100_0000, 0, 5);
    xfer(8'h20);
    tick(10);
    chk(tx_valid, 0);
    timer_val = 16'h0040;
    wait_tx(5, 0);
    tick(20);
    time_trig_mode = 1'h0;
    // unmatched stream held valid; intake is paced by ready
    {rx_id, rx_ext, rx_rtr} = {29'h1FFF_FFFF, 2'h2};
    rx_valid = 1'h1;
    n = 0;
    repeat (60)
    begin
      tick(1);
      n += (rx_ready === 1'h0);
    end
    rx_valid = 1'h0;
    chk(n > 0, 1);
    tick(80);
    chk(rx_ready, 1);
    end_sim;
  end
endmodule
